// [dxs_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
module dxs_sequencer #(
    parameter int STEPS = int'(dxs_pkg::SC_INIT)
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             cmd_valid,
    input  wire dxs_pkg::dxs_cmd_t cmd,
    input  wire logic             bus_done,
    output logic                  ready_r,
    output logic                  done_r,
    output logic                  ovf_r,
    output logic                  qerr_r,
    output dxs_pkg::dxs_cc_t      cc_r,
    output dxs_pkg::dxs_bus_t     bus_r,
    output dxs_pkg::dxs_gr_t      gr_r,
    output logic [15:0]           pc_r
);
    import dxs_pkg::*;

    // Step counter is four bits wide
    if (STEPS < 1 || STEPS > 15) begin : g_chk
        $error("STEPS out of range");
    end

    dxs_st_t     st_r;
    dxs_st_t     st_nxt;
    dxs_cmd_t    q_r;
    logic [15:0] sr_r;
    logic [15:0] dr_r;
    logic [16:0] br_r;
    logic [3:0]  sc_r;
    logic [15:0] pca_r;
    logic [15:0] addr_r;

    logic        acc;
    logic        dstep;
    logic        dsub;
    logic [17:0] shl;
    logic [17:0] dsx;
    logic [17:0] dres;
    logic        qbit;
    logic        nsub;
    logic        sdiff;
    logic        fin;
    logic [16:0] alu_v;
    logic [15:0] exv;
    logic [15:0] nres;
    logic [15:0] rneg;

    function automatic logic [16:0] alu(dxs_fn_t f, logic [15:0] s, logic [15:0] d, logic ci);
        case (f)
            FN_ADD:  alu = {1'b0, d} + {1'b0, s};
            FN_SUB:  alu = {1'b0, d} - {1'b0, s};
            FN_AND:  alu = {1'b0, d & s};
            FN_OR:   alu = {1'b0, d | s};
            FN_XOR:  alu = {1'b0, d ^ s};
            FN_ASR:  alu = {d[0], d[15], d[15:1]};
            FN_ROR:  alu = {d[0], ci, d[15:1]};
            default: alu = {1'b0, s};
        endcase
    endfunction

    function automatic logic [15:0] swp(logic [15:0] v);
        swp = {v[7:0], v[15:8]};
    endfunction

    assign acc   = cmd_valid & ready_r;
    assign dstep = (st_r == ST_DSUB) | (st_r == ST_DADD);
    assign dsub  = (st_r == ST_DFIRST) ? ~sr_r[15] : (st_r == ST_DSUB);
    // Partial remainder shifted left with next dividend bit
    assign shl   = {br_r, dr_r[15]};
    assign dsx   = {{2{sr_r[15]}}, sr_r};
    assign dres  = dsub ? shl - dsx : shl + dsx;
    assign qbit  = ~dres[17];
    // next step op from new LSB
    assign nsub  = qbit ^ sr_r[15];
    assign sdiff = q_r.nflag ^ sr_r[15];
    assign alu_v = alu(q_r.fn, sr_r, dr_r, cc_r.c);
    assign exv   = q_r.odd ? swp(alu_v[15:0]) : alu_v[15:0];
    assign nres  = dr_r + ONE16;
    assign rneg  = ~br_r[15:0] + ONE16;

    // Next machine state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (acc) begin
                    case (cmd.op)
                        OP_DIV:  st_nxt = ST_DFIRST;
                        OP_EXC:  st_nxt = ST_EXC;
                        OP_NEG:  st_nxt = ST_NEG1;
                        OP_SHR:  st_nxt = cmd.odd ? ST_SHR1 : ST_EXC;
                        OP_TST:  st_nxt = ST_TST;
                        OP_JMP:  st_nxt = ST_JMP;
                        OP_JSR:  st_nxt = ST_JSR0;
                        default: st_nxt = ST_MFP0;
                    endcase
                end
            end
            ST_DFIRST: st_nxt = qbit ? ST_IDLE : (nsub ? ST_DSUB : ST_DADD);
            ST_DSUB, ST_DADD: begin
                if (sc_r == 4'h1) begin
                    st_nxt = ST_CSTORE;
                end else begin
                    st_nxt = nsub ? ST_DSUB : ST_DADD;
                end
            end
            ST_CSTORE: st_nxt = dr_r[0] ? ST_CREM : ST_CFIX;
            ST_CFIX:   st_nxt = ST_CREM;
            ST_CREM:   st_nxt = sdiff ? ST_QONE : ST_QWR;
            ST_QONE:   st_nxt = ST_QINC;
            ST_QINC:   st_nxt = ST_IDLE;
            ST_QWR:    st_nxt = ST_IDLE;
            ST_EXC:    st_nxt = q_r.odd ? ST_EXW : ST_IDLE;
            ST_EXW:    st_nxt = bus_done ? ST_IDLE : ST_EXW;
            ST_NEG1:   st_nxt = ST_NEG2;
            ST_NEG2:   st_nxt = ST_EXW;
            ST_SHR1:   st_nxt = ST_SHR2;
            ST_SHR2:   st_nxt = ST_EXW;
            ST_TST:    st_nxt = ST_IDLE;
            ST_JMP:    st_nxt = ST_IDLE;
            ST_JSR0:   st_nxt = ST_JSR1;
            ST_JSR1:   st_nxt = ST_JSR2;
            ST_JSR2:   st_nxt = ST_JSR3;
            ST_JSR3:   st_nxt = ST_JSR4;
            ST_JSR4:   st_nxt = bus_done ? ST_IDLE : ST_JSR4;
            ST_MFP0:   st_nxt = ST_MFP1;
            ST_MFP1:   st_nxt = ST_MFP2;
            ST_MFP2:   st_nxt = ST_EXW;
            default:   st_nxt = ST_IDLE;
        endcase
    end

    assign fin = (st_r != ST_IDLE) & (st_nxt == ST_IDLE) & (st_r != ST_DFIRST);

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Working registers; divide keeps quotient in dr_r, remainder in br_r
    // divide result homes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_r    <= '0;
            sr_r   <= '0;
            dr_r   <= '0;
            br_r   <= '0;
            sc_r   <= '0;
            pca_r  <= '0;
            addr_r <= '0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (acc) begin
                        q_r  <= cmd;
                        br_r <= {1'b0, cmd.a};
                        dr_r <= cmd.b;
                        if (cmd.op == OP_DIV) begin
                            sr_r <= cmd.c;
                            sc_r <= 4'(STEPS);
                        end else begin
                            sr_r   <= cmd.a;
                            addr_r <= cmd.c;
                        end
                    end
                end
                ST_DFIRST, ST_DSUB, ST_DADD: begin
                    br_r <= dres[16:0];
                    dr_r <= {dr_r[14:0], qbit};
                    if (dstep) begin
                        sc_r <= sc_r - 4'h1;
                    end
                end
                ST_CFIX: br_r <= sr_r[15] ? br_r - {sr_r[15], sr_r} : br_r + {sr_r[15], sr_r};
                ST_QONE: dr_r <= ~dr_r;
                ST_QINC: dr_r <= nres;
                ST_EXC:  br_r <= {1'b0, exv};
                ST_SHR1: br_r <= {1'b0, alu_v[15:0]};
                ST_SHR2: br_r <= {1'b0, swp(br_r[15:0])};
                ST_NEG1: dr_r <= ~dr_r;
                ST_NEG2: br_r <= {1'b0, q_r.odd ? swp(nres) : nres};
                ST_JSR0: pca_r <= addr_r;
                ST_JSR1: br_r <= {1'b0, sr_r};
                ST_JSR2: dr_r <= dr_r - SP_DEC;
                ST_MFP0: sr_r <= dr_r;
                ST_MFP1: sr_r <= sr_r - SP_DEC;
                default: ;
            endcase
        end
    end

    // Handshake and status flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready_r <= 1'b0;
            done_r  <= 1'b0;
            ovf_r   <= 1'b0;
            qerr_r  <= 1'b0;
        end else begin
            ready_r <= (st_nxt == ST_IDLE);
            done_r  <= fin;
            ovf_r   <= (st_r == ST_DFIRST) & qbit;
            qerr_r  <= (st_r == ST_QINC) & (nres == Q_MNEG);
        end
    end

    // External transfers; write pulses last one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_r <= '0;
        end else begin
            bus_r.start <= 1'b0;
            bus_r.abort <= 1'b0;
            case (st_r)
                ST_EXC: begin
                    if (q_r.odd) begin
                        bus_r.start <= 1'b1;
                        bus_r.addr  <= addr_r;
                        bus_r.data  <= exv;
                    end
                end
                ST_NEG2: begin
                    bus_r.start <= 1'b1;
                    bus_r.addr  <= addr_r;
                    bus_r.data  <= q_r.odd ? swp(nres) : nres;
                end
                ST_SHR2: begin
                    bus_r.start <= 1'b1;
                    bus_r.addr  <= addr_r;
                    bus_r.data  <= swp(br_r[15:0]);
                end
                ST_JMP, ST_JSR0: bus_r.abort <= 1'b1;
                // push register at new stack top
                ST_JSR3: begin
                    bus_r.start <= 1'b1;
                    bus_r.addr  <= dr_r;
                    bus_r.data  <= br_r[15:0];
                end
                // abort decode transfer in mode 0
                ST_MFP0: bus_r.abort <= q_r.mode0;
                ST_MFP2: begin
                    bus_r.start <= 1'b1;
                    bus_r.addr  <= sr_r;
                    bus_r.data  <= br_r[15:0];
                end
                default: ;
            endcase
        end
    end

    // General register writes, flags and program counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gr_r <= '0;
            cc_r <= '0;
            pc_r <= '0;
        end else begin
            gr_r.we <= 1'b0;
            case (st_r)
                ST_CSTORE: gr_r <= '{1'b1, q_r.ridx | REM_ODD, br_r[15:0]};
                ST_CREM:   gr_r <= '{1'b1, q_r.ridx | REM_ODD, q_r.nflag ? rneg : br_r[15:0]};
                ST_QINC:   gr_r <= '{1'b1, q_r.ridx, nres};
                ST_QWR:    gr_r <= '{1'b1, q_r.ridx, dr_r};
                ST_JSR2:   gr_r <= '{1'b1, GR_SP, dr_r - SP_DEC};
                ST_JSR4: begin
                    if (bus_done) begin
                        gr_r <= '{1'b1, q_r.ridx, pc_r};
                        pc_r <= pca_r;
                    end
                end
                ST_MFP1:   gr_r <= '{1'b1, GR_SP, sr_r - SP_DEC};
                ST_EXC, ST_SHR1, ST_TST: cc_r <= '{alu_v[15], alu_v[15:0] == '0, 1'b0, alu_v[16]};
                ST_NEG2:   cc_r <= '{nres[15], nres == '0, nres == Q_MNEG, nres != '0};
                ST_MFP0:   cc_r <= '{br_r[15], br_r[15:0] == '0, 1'b0, cc_r.c};
                ST_JMP:    pc_r <= addr_r;
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_div_setup: assert property (acc && cmd.op == OP_DIV |=> sc_r == 4'(STEPS) && sr_r == $past(cmd.c))
        else $error("divide setup wrong");
    a_ovf_abort: assert property (st_r == ST_DFIRST && qbit |=> ovf_r && st_r == ST_IDLE)
        else $error("overflow not aborted");
    a_sub_pick: assert property (st_r == ST_DSUB |-> dr_r[0] ^ sr_r[15])
        else $error("subtract state chosen wrongly");
    a_add_pick: assert property (st_r == ST_DADD |-> !(dr_r[0] ^ sr_r[15]))
        else $error("add state chosen wrongly");
    a_qbit_in: assert property (dstep |=> dr_r[0] == !$past(dres[17]))
        else $error("quotient bit wrong");
    a_sc_step: assert property (dstep |=> sc_r == $past(sc_r) - 4'h1)
        else $error("step counter not decremented");
    a_rem_store: assert property (st_r == ST_CSTORE |=> gr_r.we && gr_r.data == $past(br_r[15:0]))
        else $error("remainder not written");
    a_rem_fix: assert property (st_r == ST_CSTORE && !dr_r[0] |=> st_r == ST_CFIX)
        else $error("correction skipped");
    a_q_mneg: assert property (st_r == ST_QINC && nres == Q_MNEG |=> qerr_r && done_r)
        else $error("most negative quotient missed");
    a_tst_nowr: assert property (st_r == ST_TST |=> !bus_r.start ##1 ready_r)
        else $error("test began a write");
    a_jmp_pc: assert property (st_r == ST_JMP |=> bus_r.abort && pc_r == $past(addr_r))
        else $error("jump pc load wrong");
    a_jsr_sp: assert property (st_r == ST_JSR2 |=> gr_r.idx == GR_SP && gr_r.data == $past(dr_r) - SP_DEC)
        else $error("stack pointer not dropped by two");
    a_odd_wr: assert property (st_r == ST_EXC && q_r.odd |=> bus_r.start ##[1:1000] st_r == ST_IDLE)
        else $error("odd byte write missing");

    c_ovf: cover property (st_r == ST_DFIRST && qbit);
    c_qneg: cover property (st_r == ST_QONE ##1 st_r == ST_QINC);
    c_jsr: cover property (st_r == ST_JSR4 && bus_done);
    c_mfp0: cover property (st_r == ST_MFP0 && q_r.mode0);
endmodule
`default_nettype wire

// [dxs_pkg.sv]
package dxs_pkg;
    localparam int          DW      = 16;
    // Divide step count, 17 octal
    localparam logic [3:0]  SC_INIT = 4'hF;
    localparam logic [15:0] SP_DEC  = 16'h0002;
    localparam logic [15:0] ONE16   = 16'h0001;
    localparam logic [15:0] Q_MNEG  = 16'h8000;
    localparam logic [2:0]  GR_SP   = 3'h6;
    localparam logic [2:0]  REM_ODD = 3'h1;

    typedef enum logic [2:0] {
        OP_DIV, OP_EXC, OP_NEG, OP_SHR, OP_TST, OP_JMP, OP_JSR, OP_MFP
    } dxs_op_t;

    typedef enum logic [2:0] {
        FN_ADD, FN_SUB, FN_AND, FN_OR, FN_XOR, FN_MOV, FN_ASR, FN_ROR
    } dxs_fn_t;

    // a/b/c meaning depends on op
    typedef struct packed {
        dxs_op_t     op;
        dxs_fn_t     fn;
        logic        odd;
        logic        mode0;
        logic        nflag;
        logic [2:0]  ridx;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
    } dxs_cmd_t;

    typedef struct packed {
        logic        start;
        logic        abort;
        logic [15:0] addr;
        logic [15:0] data;
    } dxs_bus_t;

    typedef struct packed {
        logic        we;
        logic [2:0]  idx;
        logic [15:0] data;
    } dxs_gr_t;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } dxs_cc_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h00, ST_DFIRST = 5'h01, ST_DSUB = 5'h03, ST_DADD = 5'h02,
        ST_CSTORE = 5'h06, ST_CFIX = 5'h07, ST_CREM = 5'h05, ST_QONE = 5'h04,
        ST_QINC = 5'h0C, ST_QWR = 5'h0D, ST_EXC = 5'h0F, ST_EXW = 5'h0E,
        ST_NEG1 = 5'h0A, ST_NEG2 = 5'h0B, ST_SHR1 = 5'h09, ST_SHR2 = 5'h08,
        ST_JMP = 5'h18, ST_JSR0 = 5'h19, ST_JSR1 = 5'h1B, ST_JSR2 = 5'h1A,
        ST_JSR3 = 5'h1E, ST_JSR4 = 5'h1F, ST_MFP0 = 5'h1D, ST_MFP1 = 5'h1C,
        ST_MFP2 = 5'h14, ST_TST = 5'h15
    } dxs_st_t;
endpackage

// [dxs_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module dxs_mem_model (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire dxs_pkg::dxs_bus_t bus,
    input  wire logic [3:0]        lat,
    output logic                   bus_done,
    output logic [15:0]            wr_addr,
    output logic [15:0]            wr_data
);
    import dxs_pkg::*;

    logic [3:0] cnt_r;
    logic       busy_r;

    // Take one write, answer after lat extra cycles; a second start while busy is dropped
    always_ff @(posedge clk) begin
        bus_done <= 1'b0;
        if (!rst_n) begin
            busy_r  <= 1'b0;
            cnt_r   <= 4'h0;
            wr_addr <= 16'h0000;
            wr_data <= 16'h0000;
        end else if (bus.start && !busy_r) begin
            busy_r  <= 1'b1;
            cnt_r   <= lat;
            wr_addr <= bus.addr;
            wr_data <= bus.data;
        end else if (busy_r) begin
            if (cnt_r == 4'h0) begin
                busy_r   <= 1'b0;
                bus_done <= 1'b1;
            end else begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import dxs_pkg::*;

    logic        clk, rst_n, cmd_valid, bus_done, ready_r, done_r, ovf_r, qerr_r;
    dxs_cmd_t    cmd;
    dxs_cc_t     cc_r;
    dxs_bus_t    bus_r;
    dxs_gr_t     gr_r;
    logic [15:0] pc_r, wr_addr, wr_data;
    logic [3:0]  lat;
    logic [15:0] gr_seen [8];
    int          err_count, checked, starts, aborts, cycles;
    logic        saw_done, saw_ovf, saw_qerr;

    initial clk = 1'b0;
    always #4 clk = ~clk;

    dxs_sequencer dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .bus_done(bus_done),
        .ready_r(ready_r), .done_r(done_r), .ovf_r(ovf_r), .qerr_r(qerr_r), .cc_r(cc_r), .bus_r(bus_r),
        .gr_r(gr_r), .pc_r(pc_r));
    dxs_mem_model mem (.clk(clk), .rst_n(rst_n), .bus(bus_r), .lat(lat), .bus_done(bus_done),
        .wr_addr(wr_addr), .wr_data(wr_data));

    // Pulses are logged one edge after they rise; hang guard trips at 20000 cycles, far above the few hundred cycles of work
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (gr_r.we === 1'b1) gr_seen[gr_r.idx] <= gr_r.data;
        if (bus_r.start === 1'b1) starts <= starts + 1;
        if (bus_r.abort === 1'b1) aborts <= aborts + 1;
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic dxs_cmd_t mk(dxs_op_t op, dxs_fn_t fn, logic odd, logic m0, logic nf,
                                    logic [2:0] ri, logic [15:0] a, logic [15:0] b, logic [15:0] c);
        return '{op, fn, odd, m0, nf, ri, a, b, c};
    endfunction

    // Offer a command, hold it until taken, then wait for done or overflow
    task automatic run(input dxs_cmd_t c);
        int n;
        @(posedge clk);
        cmd       <= c;
        cmd_valid <= 1'b1;
        #1;
        for (int k = 0; k < 8; k++) gr_seen[k] = 'x;
        starts = 0;
        aborts = 0;
        while (ready_r !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done_r !== 1'b1 && ovf_r !== 1'b1 && n < 300);
        saw_done = done_r;
        saw_ovf  = ovf_r;
        saw_qerr = qerr_r;
        check("answered", 16'(n < 300), 16'h0001);
        @(posedge clk);
        #1;
    endtask

    // Expected results by plain arithmetic on the positive magnitude
    task automatic div_one(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input logic nf);
        logic [31:0] dvd;
        logic [15:0] q, r, mag;
        dvd = {a, b};
        mag = c[15] ? -c : c;
        q = 16'(dvd / {16'h0000, mag});
        r = 16'(dvd % {16'h0000, mag});
        // Quotient sign from both operands, remainder sign from the dividend
        if (nf ^ c[15]) begin
            q = -q;
        end
        if (nf) begin
            r = -r;
        end
        run(mk(OP_DIV, FN_ADD, 1'b0, 1'b0, nf, 3'h2, a, b, c));
        check("div_done", 16'(saw_done), 16'h0001);
        check("quotient", gr_seen[2], q);
        check("remainder", gr_seen[3], r);
    endtask

    // Mixed quotient bits, a correction case, negative original dividend
    task automatic t_div;
        div_one(16'h0000, 16'h0064, 16'h0007, 1'b0);
        div_one(16'h0001, 16'h2345, 16'h0123, 1'b0);
        div_one(16'h3FFF, 16'h0000, 16'h7FFF, 1'b0);
        div_one(16'h0000, 16'h0064, 16'h0007, 1'b1);
        // Negative divisor walks the add-first path
        div_one(16'h0000, 16'h0064, 16'hFFF9, 1'b0);
    endtask

    // High half equal to divisor cannot fit a 16-bit quotient
    task automatic t_ovf;
        run(mk(OP_DIV, FN_ADD, 1'b0, 1'b0, 1'b0, 3'h2, 16'h0007, 16'h0000, 16'h0007));
        check("ovf", 16'(saw_ovf), 16'h0001);
        check("ovf_done", 16'(saw_done), 16'h0000);
    endtask

    // A 0x8000 quotient is caught by the first-cycle test; largest legal one negates cleanly
    task automatic t_qerr;
        run(mk(OP_DIV, FN_ADD, 1'b0, 1'b0, 1'b1, 3'h2, 16'h0000, 16'h8000, 16'h0001));
        check("qerr", 16'(saw_qerr), 16'h0000);
        check("qerr_ovf", 16'(saw_ovf), 16'h0001);
        div_one(16'h0000, 16'h7FFF, 16'h0001, 1'b1);
        check("qerr_edge", 16'(saw_qerr), 16'h0000);
    endtask

    // Even byte keeps the result inside; odd byte writes with a slow memory
    task automatic t_exc;
        lat = 4'h0;
        run(mk(OP_EXC, FN_XOR, 1'b0, 1'b0, 1'b0, 3'h0, 16'h5A5A, 16'h5A5A, 16'h0400));
        check("exc_even_wr", 16'(starts), 16'h0000);
        check("exc_nz", {14'h0, cc_r.n, cc_r.z}, 16'h0001);
        lat = 4'h5;
        run(mk(OP_EXC, FN_ADD, 1'b1, 1'b0, 1'b0, 3'h0, 16'h1111, 16'h2222, 16'h0401));
        check("exc_odd_wr", 16'(starts), 16'h0001);
        check("exc_odd_addr", wr_addr, 16'h0401);
        check("exc_odd_done", 16'(saw_done), 16'h0001);
    endtask

    // Negate and odd-byte right shift each write once
    task automatic t_neg_shr;
        lat = 4'h1;
        run(mk(OP_NEG, FN_SUB, 1'b1, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h0001, 16'h0601));
        check("neg_wr", 16'(starts), 16'h0001);
        check("neg_addr", wr_addr, 16'h0601);
        run(mk(OP_SHR, FN_ASR, 1'b1, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h8080, 16'h0701));
        check("shr_wr", 16'(starts), 16'h0001);
        check("shr_addr", wr_addr, 16'h0701);
        check("shr_data", wr_data, 16'h40C0);
    endtask

    // Test on an odd byte still never writes
    task automatic t_tst;
        run(mk(OP_TST, FN_SUB, 1'b1, 1'b0, 1'b0, 3'h0, 16'h0003, 16'h0003, 16'h0801));
        check("tst_wr", 16'(starts), 16'h0000);
        check("tst_done", 16'(saw_done), 16'h0001);
    endtask

    // Jump loads the address, not the data word
    task automatic t_jmp;
        run(mk(OP_JMP, FN_MOV, 1'b0, 1'b0, 1'b0, 3'h0, 16'h0000, 16'hBEEF, 16'h1234));
        check("jmp_pc", pc_r, 16'h1234);
        check("jmp_abort", 16'(aborts), 16'h0001);
        check("jmp_wr", 16'(starts), 16'h0000);
    endtask

    // Call after the jump, so the link value is known
    task automatic t_jsr;
        lat = 4'h3;
        run(mk(OP_JSR, FN_MOV, 1'b0, 1'b0, 1'b0, 3'h5, 16'hA5A5, 16'h0100, 16'h2000));
        check("jsr_sp", gr_seen[6], 16'h00FE);
        check("jsr_addr", wr_addr, 16'h00FE);
        check("jsr_data", wr_data, 16'hA5A5);
        check("jsr_link", gr_seen[5], 16'h1234);
        check("jsr_pc", pc_r, 16'h2000);
    endtask

    // Register-mode push drops the decode fetch and pushes register data
    task automatic t_mfp;
        lat = 4'h0;
        run(mk(OP_MFP, FN_MOV, 1'b0, 1'b1, 1'b0, 3'h0, 16'h3C3C, 16'h0200, 16'h0000));
        check("mfp_abort", 16'(aborts), 16'h0001);
        check("mfp_sp", gr_seen[6], 16'h01FE);
        check("mfp_addr", wr_addr, 16'h01FE);
        check("mfp_data", wr_data, 16'h3C3C);
    endtask

    task automatic end_sim;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Reset held four cycles, then every scenario in turn
    initial begin
        rst_n     = 1'b0;
        cmd_valid = 1'b0;
        cmd       = '0;
        lat       = 4'h0;
        err_count = 0;
        checked   = 0;
        cycles    = 0;
        starts    = 0;
        aborts    = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_div();
        t_ovf();
        t_qerr();
        t_exc();
        t_neg_shr();
        t_tst();
        t_jmp();
        t_jsr();
        t_mfp();
        end_sim();
    end
endmodule
`default_nettype wire
